// ---- core/adcs_defs.svh ----
`ifndef ADCS_DEFS_SVH
`define ADCS_DEFS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define ADCS_OFS_CTRL_A 8'h00
`define ADCS_OFS_CTRL_B 8'h04
`define ADCS_OFS_CTRL_C 8'h08
`define ADCS_OFS_CTRL_D 8'h0c
`define ADCS_OFS_STATUS 8'h10
`define ADCS_OFS_RES0 8'h20
`define ADCS_OFS_RES7 8'h3c
// ----------------------------------------
// field positions
// ----------------------------------------
`define ADCS_A_MODE 0
`define ADCS_A_CHAN 2
`define ADCS_A_TRGSEL 5
`define ADCS_A_START 6
`define ADCS_B_SWPINS 0
`define ADCS_B_SWONE 2
`define ADCS_B_EXTIN 6
`define ADCS_C_GROUP 4
`define ADCS_C_TRGSRC 7
`define ADCS_D_DMA 2
`define ADCS_D_MPORT 5
// ----------------------------------------
// reset values, responses, timing
// ----------------------------------------
`define ADCS_CTRL_RST 8'h00
`define ADCS_RESP_OK 2'h0
`define ADCS_RESP_ERR 2'h2
`define ADCS_CONV_CYC 16
`endif

// ---- core/adcs_pkg.sv ----
package adcs_pkg;
  typedef enum logic [2:0] {
    ADCS_IDLE = 3'h1,
    ADCS_ARMED = 3'h2,
    ADCS_CONV = 3'h4
  } adcs_fsm_e;

  typedef enum logic [2:0] {
    ADCS_M_ONE = 3'h0,
    ADCS_M_REP = 3'h1,
    ADCS_M_SSW = 3'h2,
    ADCS_M_RSW0 = 3'h3,
    ADCS_M_RSW1 = 3'h4,
    ADCS_M_MPS = 3'h5,
    ADCS_M_MPR = 3'h6,
    ADCS_M_BAD = 3'h7
  } adcs_mode_e;

  typedef struct packed {
    logic [1:0] mode;
    logic [2:0] chan;
    logic trigSel;
    logic start;
    logic [1:0] sweepPins;
    logic sweepOne;
    logic [1:0] extIn;
    logic [1:0] groupSel;
    logic trigSrc;
    logic multiport;
    logic dmaUse;
  } adcs_ctrl_s;

  typedef struct packed {
    logic dma;
    logic [2:0] idx;
    logic [9:0] data;
  } adcs_res_s;
endpackage

// ---- core/adcs_seq.sv ----
// Chosen here: the address map and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "adcs_defs.svh"

module adcs_fifo #(
  parameter int Width = 14,
  parameter int Depth = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [Width-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [Width-1:0] outData
);
  localparam int Aw = $clog2(Depth);
  typedef struct packed {
    logic [Aw-1:0] wp;
    logic [Aw-1:0] rp;
    logic [Aw:0] count;
  } adcs_fifo_s;
  adcs_fifo_s st_reg, st_next;
  logic [Width-1:0] mem [Depth];
  logic wrEn, rdEn;

  assign inReady = st_reg.count != (Aw+1)'(Depth);
  assign outValid = st_reg.count != '0;
  assign outData = mem[st_reg.rp];
  assign wrEn = inValid && inReady;
  assign rdEn = outValid && outReady;

  always_comb begin
    st_next = st_reg;
    if (wrEn) begin
      st_next.wp = (st_reg.wp == Aw'(Depth-1)) ? '0 : st_reg.wp + 1'h1;
    end
    if (rdEn) begin
      st_next.rp = (st_reg.rp == Aw'(Depth-1)) ? '0 : st_reg.rp + 1'h1;
    end
    st_next.count = st_reg.count + (Aw+1)'(wrEn) - (Aw+1)'(rdEn);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
    if (wrEn) begin
      mem[st_reg.wp] <= inData;
    end
  end
endmodule // adcs_fifo

module adcs_seq #(
  parameter int ConvCycles = `ADCS_CONV_CYC,
  parameter int FifoDepth = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic extTriggerPin,
  input wire logic motorTimerIrq,
  input wire logic [9:0] anaData,
  output logic [5:0] chanSel,
  output logic convActive,
  output logic convIrq,
  output logic dmaReq,
  input wire logic dmaAck
);
  typedef struct packed {
    logic awHave;
    logic wHave;
    logic [7:0] awAddr;
    logic [7:0] wData;
    logic wLow;
    logic bValid;
    logic [1:0] bResp;
    logic arRdy;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    adcs_pkg::adcs_ctrl_s ctl;
    adcs_pkg::adcs_fsm_e fsm;
    logic [15:0] cnt;
    logic pinPrev;
    logic convIrq;
    logic [5:0] chanSel;
    logic [7:0][9:0] res;
    logic firstFull;
    logic awRdy, wRdy, convAct;
  } adcs_state_s;

  adcs_state_s st_reg, st_next;
  adcs_pkg::adcs_res_s fIn, fOut;
  logic fInValid, fInReady, fOutValid, fOutReady;
  logic doWr, push, hwTrig, single;
  adcs_pkg::adcs_mode_e modeNow;
  logic [5:0] selNow;
  logic [33:0] wrLook;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic adcs_pkg::adcs_mode_e modeOf(adcs_pkg::adcs_ctrl_s c);
    modeOf = adcs_pkg::ADCS_M_BAD;
    if (!c.multiport) begin
      case (c.mode)
        2'h0: if (!c.sweepOne) modeOf = adcs_pkg::ADCS_M_ONE;
        2'h1: if (!c.sweepOne) modeOf = adcs_pkg::ADCS_M_REP;
        2'h2: if (!c.sweepOne) modeOf = adcs_pkg::ADCS_M_SSW;
        default: modeOf = c.sweepOne ? adcs_pkg::ADCS_M_RSW1
                                     : adcs_pkg::ADCS_M_RSW0;
      endcase
    end else if (c.dmaUse && !c.sweepOne && c.mode[1]) begin
      modeOf = c.mode[0] ? adcs_pkg::ADCS_M_MPR
                         : adcs_pkg::ADCS_M_MPS;
    end
  endfunction

  // extended inputs sit above the four groups of eight
  function automatic logic [5:0] chanOf(adcs_pkg::adcs_ctrl_s c);
    if (c.extIn == 2'h1) begin
      chanOf = 6'h20;
    end else if (c.extIn == 2'h2) begin
      chanOf = 6'h21;
    end else begin
      chanOf = {1'h0, c.groupSel, c.chan};
    end
  endfunction

  function automatic logic [33:0] regRd(logic [7:0] a, adcs_state_s s);
    regRd = {`ADCS_RESP_OK, 32'h0};
    if (a == `ADCS_OFS_CTRL_A) begin
      regRd[7:0] = {1'h0, s.ctl.start, s.ctl.trigSel, s.ctl.chan,
                    s.ctl.mode};
    end else if (a == `ADCS_OFS_CTRL_B) begin
      regRd[7:0] = {s.ctl.extIn, 3'h0, s.ctl.sweepOne, s.ctl.sweepPins};
    end else if (a == `ADCS_OFS_CTRL_C) begin
      regRd[7:0] = {s.ctl.trigSrc, 1'h0, s.ctl.groupSel, 4'h0};
    end else if (a == `ADCS_OFS_CTRL_D) begin
      regRd[7:0] = {2'h0, s.ctl.multiport, 2'h0, s.ctl.dmaUse, 2'h0};
    end else if (a == `ADCS_OFS_STATUS) begin
      regRd[6:0] = {s.firstFull, s.fsm, modeOf(s.ctl)};
    end else if (a >= `ADCS_OFS_RES0 && a <= `ADCS_OFS_RES7 &&
                 a[1:0] == 2'h0) begin
      regRd[9:0] = s.res[a[4:2]];
    end else begin
      regRd[33:32] = `ADCS_RESP_ERR;
    end
  endfunction

  // ----------------------------------------
  // result buffer
  // ----------------------------------------
  // a full buffer holds the sequencer at the end of a conversion
  adcs_fifo #(.Width(14), .Depth(FifoDepth)) resFifo (
    .mclk(mclk),
    .rst(rst),
    .inValid(fInValid),
    .inReady(fInReady),
    .inData(fIn),
    .outValid(fOutValid),
    .outReady(fOutReady),
    .outData(fOut)
  );

  assign modeNow = modeOf(st_reg.ctl);
  assign selNow = chanOf(st_reg.ctl);
  assign wrLook = regRd(st_reg.awAddr, st_reg);
  assign single = modeNow == adcs_pkg::ADCS_M_ONE ||
                  modeNow == adcs_pkg::ADCS_M_REP;
  // edges only count once start is already set
  assign hwTrig = st_reg.ctl.trigSrc ? motorTimerIrq
                : st_reg.pinPrev && !extTriggerPin;
  assign fInValid = push;
  assign fIn = '{dma: st_reg.ctl.dmaUse, idx: st_reg.ctl.chan,
                 data: anaData};

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.convIrq = 1'h0;
    st_next.pinPrev = extTriggerPin;
    push = 1'h0;
    fOutReady = 1'h0;
    if (st_reg.fsm != adcs_pkg::ADCS_CONV) begin
      st_next.chanSel = selNow;
    end
    case (st_reg.fsm)
      adcs_pkg::ADCS_IDLE: begin
        if (st_reg.ctl.start && single) begin
          st_next.cnt = 16'(ConvCycles - 1);
          st_next.fsm = st_reg.ctl.trigSel ? adcs_pkg::ADCS_ARMED
                                           : adcs_pkg::ADCS_CONV;
        end
      end
      adcs_pkg::ADCS_ARMED: begin
        if (!st_reg.ctl.start || !single) begin
          st_next.fsm = adcs_pkg::ADCS_IDLE;
        end else if (hwTrig) begin
          st_next.cnt = 16'(ConvCycles - 1);
          st_next.fsm = adcs_pkg::ADCS_CONV;
        end
      end
      adcs_pkg::ADCS_CONV: begin
        if (!st_reg.ctl.start || !single) begin
          st_next.fsm = adcs_pkg::ADCS_IDLE;
        end else if (st_reg.cnt != 16'h0) begin
          st_next.cnt = st_reg.cnt - 16'h1;
        end else if (fInReady) begin
          push = 1'h1;
          if (modeNow == adcs_pkg::ADCS_M_ONE) begin
            st_next.convIrq = 1'h1;
            if (!st_reg.ctl.trigSel) begin
              st_next.ctl.start = 1'h0;
              st_next.fsm = adcs_pkg::ADCS_IDLE;
            end else begin
              st_next.fsm = adcs_pkg::ADCS_ARMED;
            end
          end else begin
            st_next.convIrq = st_reg.ctl.dmaUse;
            st_next.cnt = 16'(ConvCycles - 1);
          end
        end
      end
      default: st_next.fsm = adcs_pkg::ADCS_IDLE;
    endcase
    // drain: the first result slot waits for the dma to take it
    if (dmaAck) begin
      st_next.firstFull = 1'h0;
    end
    if (fOutValid) begin
      if (!fOut.dma) begin
        fOutReady = 1'h1;
        st_next.res[fOut.idx] = fOut.data;
      end else if (!st_reg.firstFull || dmaAck) begin
        fOutReady = 1'h1;
        st_next.res[0] = fOut.data;
        st_next.firstFull = 1'h1;
      end
    end
    // bus write, after the sequencer so a software set wins
    if (awvalid && !st_reg.awHave) begin
      st_next.awHave = 1'h1;
      st_next.awAddr = awaddr;
    end
    if (wvalid && !st_reg.wHave) begin
      st_next.wHave = 1'h1;
      st_next.wData = wdata[7:0];
      st_next.wLow = wstrb[0];
    end
    if (st_reg.bValid && bready) begin
      st_next.bValid = 1'h0;
    end
    doWr = st_reg.awHave && st_reg.wHave && !st_reg.bValid;
    if (doWr) begin
      st_next.awHave = 1'h0;
      st_next.wHave = 1'h0;
      st_next.bValid = 1'h1;
      st_next.bResp = wrLook[33:32];
      if (st_reg.wLow) begin
        if (st_reg.awAddr == `ADCS_OFS_CTRL_A) begin
          st_next.ctl.mode = st_reg.wData[`ADCS_A_MODE +: 2];
          st_next.ctl.chan = st_reg.wData[`ADCS_A_CHAN +: 3];
          st_next.ctl.trigSel = st_reg.wData[`ADCS_A_TRGSEL];
          st_next.ctl.start = st_reg.wData[`ADCS_A_START];
        end else if (st_reg.awAddr == `ADCS_OFS_CTRL_B) begin
          st_next.ctl.sweepPins = st_reg.wData[`ADCS_B_SWPINS +: 2];
          st_next.ctl.sweepOne = st_reg.wData[`ADCS_B_SWONE];
          st_next.ctl.extIn = st_reg.wData[`ADCS_B_EXTIN +: 2];
        end else if (st_reg.awAddr == `ADCS_OFS_CTRL_C) begin
          st_next.ctl.groupSel = st_reg.wData[`ADCS_C_GROUP +: 2];
          st_next.ctl.trigSrc = st_reg.wData[`ADCS_C_TRGSRC];
        end else if (st_reg.awAddr == `ADCS_OFS_CTRL_D) begin
          st_next.ctl.dmaUse = st_reg.wData[`ADCS_D_DMA];
          st_next.ctl.multiport = st_reg.wData[`ADCS_D_MPORT];
        end
      end
    end
    if (st_reg.rValid && rready) begin
      st_next.rValid = 1'h0;
      st_next.arRdy = 1'h1;
    end
    if (st_reg.arRdy && arvalid) begin
      st_next.arRdy = 1'h0;
      st_next.rValid = 1'h1;
      {st_next.rResp, st_next.rData} = regRd(araddr, st_reg);
    end
    // registered copies keep ready and busy outputs glitch free
    st_next.awRdy = !st_next.awHave;
    st_next.wRdy = !st_next.wHave;
    st_next.convAct = st_next.fsm == adcs_pkg::ADCS_CONV;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.ctl <= adcs_pkg::adcs_ctrl_s'(`ADCS_CTRL_RST);
      st_reg.fsm <= adcs_pkg::ADCS_IDLE;
      st_reg.arRdy <= 1'h1;
      st_reg.awRdy <= 1'h1;
      st_reg.wRdy <= 1'h1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign awready = st_reg.awRdy;
  assign wready = st_reg.wRdy;
  assign bvalid = st_reg.bValid;
  assign bresp = st_reg.bResp;
  assign arready = st_reg.arRdy;
  assign rvalid = st_reg.rValid;
  assign rdata = st_reg.rData;
  assign rresp = st_reg.rResp;
  assign chanSel = st_reg.chanSel;
  assign convActive = st_reg.convAct;
  assign convIrq = st_reg.convIrq;
  assign dmaReq = st_reg.firstFull;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  mode_decode_a: assert property (
    (!st_reg.ctl.multiport && !st_reg.ctl.sweepOne &&
     st_reg.ctl.mode == 2'h1) |-> modeNow == adcs_pkg::ADCS_M_REP)
    else $error("repeat mode misdecoded");
  one_shot_a: assert property (
    (push && modeNow == adcs_pkg::ADCS_M_ONE)
    |=> st_reg.fsm != adcs_pkg::ADCS_CONV)
    else $error("one-shot kept converting");
  sw_start_a: assert property (
    (st_reg.fsm == adcs_pkg::ADCS_IDLE && st_reg.ctl.start && single &&
     !st_reg.ctl.trigSel) |=> convActive && chanSel == $past(selNow))
    else $error("software start missed");
  hw_start_a: assert property (
    (st_reg.fsm == adcs_pkg::ADCS_ARMED && st_reg.ctl.start && single &&
     hwTrig) |=> convActive)
    else $error("hardware trigger missed");
  no_early_a: assert property (
    (st_reg.fsm == adcs_pkg::ADCS_ARMED && !hwTrig) |=> !convActive)
    else $error("conversion without trigger");
  start_clear_a: assert property (
    (push && modeNow == adcs_pkg::ADCS_M_ONE && !st_reg.ctl.trigSel &&
     !doWr) |=> !st_reg.ctl.start ##1 !convActive)
    else $error("start bit not cleared");
  abort_a: assert property (
    (convActive && !st_reg.ctl.start) |=> !convActive)
    else $error("abort ignored");
  irq_pulse_a: assert property (
    (push && modeNow == adcs_pkg::ADCS_M_ONE) |=> convIrq ##1 !convIrq)
    else $error("one-shot request missing");
  repeat_irq_a: assert property (
    (push && modeNow == adcs_pkg::ADCS_M_REP)
    |=> convIrq == $past(st_reg.ctl.dmaUse))
    else $error("repeat request wrong");
  repeat_keep_a: assert property (
    (push && modeNow == adcs_pkg::ADCS_M_REP && !doWr)
    |=> st_reg.ctl.start && convActive &&
        st_reg.cnt == 16'(ConvCycles - 1))
    else $error("repeat did not restart");
  chan_store_a: assert property (
    (fOutValid && !fOut.dma) |=> st_reg.res[$past(fOut.idx)] ==
                                 $past(fOut.data))
    else $error("channel result not stored");
  dma_store_a: assert property (
    (fOutValid && fOutReady && fOut.dma)
    |=> dmaReq && st_reg.res[0] == $past(fOut.data))
    else $error("first result not stored");
endmodule // adcs_seq

// ---- verification/adcs_dma_model.sv ----
`timescale 1ns/10ps
// ----
// dma side: empties the first result
// ----
module adcs_dma_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic dmaReq,
  input wire logic [3:0] lag,
  input wire logic park,
  output logic dmaAck
);
  logic [3:0] waitCnt;
  // ack is a one-cycle pulse; the wait restarts for each value
  always_ff @(posedge mclk) begin
    if (rst || !dmaReq || dmaAck) begin
      waitCnt <= 4'h0;
      dmaAck <= 1'h0;
    end else if (!park && waitCnt >= lag) begin
      dmaAck <= 1'h1;
    end else if (waitCnt != 4'hf) begin
      waitCnt <= waitCnt + 4'h1;
    end
  end
endmodule // adcs_dma_model

// ---- verification/adcs_seq_test.sv ----
`timescale 1ns/10ps
`include "adcs_defs.svh"
module adcs_seq_test;
  localparam int ConvCyc = 8;
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid;
  logic convActive, convIrq, dmaReq, dmaAck;
  logic [1:0] bresp, rresp, rs, g, e;
  logic [31:0] rdata, rd;
  logic pin = 1'h1, tmr = 1'h0, park = 1'h0;
  logic [9:0] ana = 10'h000;
  logic [5:0] chanSel, lastSel;
  logic [2:0] c;
  logic [3:0] lag = 4'h2;
  int errCount = 0, testsRun = 0, irqs = 0, i, n0, gaps;
  // {mode, sweepOne, multiport, dmaUse, expected code}
  logic [7:0] modeTab [8] = '{8'h00, 8'h41, 8'h8a, 8'hc3, 8'he4,
    8'h9d, 8'hde, 8'h1f};
  // {group, chan, extIn}
  logic [6:0] selTab [4] = '{7'h54, 7'h7c, 7'h05, 7'h2a};

  always #4 mclk = ~mclk;
  always @(posedge mclk) begin
    if (convIrq === 1'h1) irqs++;
    if (convActive === 1'h1) lastSel <= chanSel;
  end

  adcs_seq #(.ConvCycles(ConvCyc)) uut (.mclk(mclk), .rst(rst),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .extTriggerPin(pin), .motorTimerIrq(tmr), .anaData(ana),
    .chanSel(chanSel), .convActive(convActive), .convIrq(convIrq),
    .dmaReq(dmaReq), .dmaAck(dmaAck));
  adcs_dma_model dma (.mclk(mclk), .rst(rst), .dmaReq(dmaReq),
    .lag(lag), .park(park), .dmaAck(dmaAck));

  task automatic conclude();
    $display("errors %0d compares %0d", errCount, testsRun);
    if (errCount == 0 && testsRun > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic hang();
    errCount++;
    conclude();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      errCount++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // ----
  // bus master; every wait is bounded
  // ----
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic aw, w;
    aw = 1'h0;
    w = 1'h0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (n = 0; n < 64; n++) begin
      @(posedge mclk);
      if (!aw && awready === 1'h1) begin
        aw = 1'h1;
        awvalid <= 1'h0;
      end
      if (!w && wready === 1'h1) begin
        w = 1'h1;
        wvalid <= 1'h0;
      end
      if (bvalid === 1'h1) break;
    end
    rs = bresp;
    if (n == 64) hang();
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    int n;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (n = 0; n < 64; n++) begin
      @(posedge mclk);
      if (arready === 1'h1) arvalid <= 1'h0;
      if (rvalid === 1'h1) break;
    end
    rd = rdata;
    rs = rresp;
    if (n == 64) hang();
    chk(rd, exp);
  endtask
  task automatic waitIrq();
    int n;
    for (n = 0; n < 200 && convIrq !== 1'h1; n++) @(posedge mclk);
    if (n == 200) hang();
  endtask
  task automatic drain();
    int n;
    for (n = 0; n < 400 && dmaReq !== 1'h0; n++) @(posedge mclk);
    if (n == 400) hang();
  endtask

  initial begin
    cyc(10);
    rst <= 1'h0;
    cyc(1);
    rdChk(`ADCS_OFS_STATUS, 32'h08);
    wr(8'h44, 32'h1);
    chk(rs, `ADCS_RESP_ERR);
    rdChk(8'h44, 32'h0);
    chk(rs, `ADCS_RESP_ERR);
    for (i = 0; i < 8; i++) begin
      wr(`ADCS_OFS_CTRL_B, {29'h0, modeTab[i][5], 2'h3});
      wr(`ADCS_OFS_CTRL_D, {26'h0, modeTab[i][4], 2'h0, modeTab[i][3],
                            2'h0});
      wr(`ADCS_OFS_CTRL_A, {30'h0, modeTab[i][7:6]});
      rdChk(`ADCS_OFS_STATUS, {26'h0, 3'h1, modeTab[i][2:0]});
    end
    wr(`ADCS_OFS_CTRL_D, 32'h0);
    wr(`ADCS_OFS_CTRL_B, 32'h0);
    for (i = 0; i < 4; i++) begin
      {g, c, e} = selTab[i];
      ana <= 10'h2a5 ^ 10'(i);
      wr(`ADCS_OFS_CTRL_C, {26'h0, g, 4'h0});
      wr(`ADCS_OFS_CTRL_B, {24'h0, e, 6'h0});
      n0 = irqs;
      wr(`ADCS_OFS_CTRL_A, {25'h0, 2'h2, c, 2'h0});
      waitIrq();
      cyc(2 * ConvCyc);
      chk(32'(irqs - n0), 32'h1);
      chk({26'h0, lastSel}, e == 2'h0 ? {27'h0, g, c} : 32'h1f + e);
      rdChk(`ADCS_OFS_CTRL_A, {27'h0, c, 2'h0});
      rdChk(8'h20 + {3'h0, c, 2'h0}, {22'h0, ana});
    end
    wr(`ADCS_OFS_CTRL_B, 32'h0);
    wr(`ADCS_OFS_CTRL_C, 32'h0);
    // abort lands well inside the conversion time
    n0 = irqs;
    wr(`ADCS_OFS_CTRL_A, 32'h40);
    wr(`ADCS_OFS_CTRL_A, 32'h00);
    cyc(3 * ConvCyc);
    chk(32'(irqs - n0), 32'h0);
    chk({31'h0, convActive}, 32'h0);
    // edge before arming must not count
    pin <= 1'h0;
    cyc(2);
    wr(`ADCS_OFS_CTRL_A, 32'h60);
    cyc(3 * ConvCyc);
    chk(32'(irqs - n0), 32'h0);
    pin <= 1'h1;
    cyc(2);
    pin <= 1'h0;
    waitIrq();
    pin <= 1'h1;
    wr(`ADCS_OFS_CTRL_A, 32'h00);
    wr(`ADCS_OFS_CTRL_C, 32'h80);
    tmr <= 1'h1;
    cyc(1);
    tmr <= 1'h0;
    n0 = irqs;
    wr(`ADCS_OFS_CTRL_A, 32'h60);
    cyc(3 * ConvCyc);
    chk(32'(irqs - n0), 32'h0);
    tmr <= 1'h1;
    cyc(1);
    tmr <= 1'h0;
    waitIrq();
    wr(`ADCS_OFS_CTRL_A, 32'h00);
    wr(`ADCS_OFS_CTRL_C, 32'h00);
    // repeat without dma
    ana <= 10'h1e1;
    wr(`ADCS_OFS_CTRL_A, 32'h41);
    n0 = irqs;
    gaps = 0;
    cyc(3);
    for (i = 0; i < 6 * ConvCyc; i++) begin
      @(posedge mclk);
      if (convActive !== 1'h1) gaps++;
    end
    chk(32'(gaps), 32'h0);
    chk(32'(irqs - n0), 32'h0);
    rdChk(`ADCS_OFS_CTRL_A, 32'h41);
    rdChk(`ADCS_OFS_RES0, 32'h1e1);
    wr(`ADCS_OFS_CTRL_A, 32'h01);
    cyc(2);
    chk({31'h0, convActive}, 32'h0);
    // repeat with dma, prompt partner
    wr(`ADCS_OFS_CTRL_D, 32'h04);
    ana <= 10'h3c3;
    wr(`ADCS_OFS_CTRL_A, 32'h41);
    n0 = irqs;
    cyc(6 * ConvCyc);
    i = irqs - n0;
    chk(32'(i >= 4 && i <= 7), 32'h1);
    wr(`ADCS_OFS_CTRL_A, 32'h01);
    drain();
    rdChk(`ADCS_OFS_RES0, 32'h3c3);
    // stalled partner: buffer fills, then drains slowly
    park <= 1'h1;
    lag <= 4'h9;
    wr(`ADCS_OFS_CTRL_A, 32'h41);
    cyc(20 * ConvCyc);
    chk({31'h0, dmaReq}, 32'h1);
    wr(`ADCS_OFS_CTRL_A, 32'h01);
    park <= 1'h0;
    drain();
    chk({31'h0, dmaReq}, 32'h0);
    // one-shot with dma goes to the first result
    ana <= 10'h0f0;
    wr(`ADCS_OFS_CTRL_A, 32'h4c);
    waitIrq();
    cyc(2);
    chk({31'h0, dmaReq}, 32'h1);
    drain();
    rdChk(`ADCS_OFS_RES0, 32'h0f0);
    conclude();
  end
endmodule // adcs_seq_test
